// file: logic/adc_config_reset_registers.sv
// Register core: configuration words, alert flags and reset commands.
// Assumes a host on the same clock using one-cycle read/write strobes.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
module adc_config_reset_registers
  import acrr_pkg::*;
(
  input  wire logic        ref_clk,        // 250 MHz clock
  input  wire logic        rst,            // Async reset, high
  input  wire logic [3:0]  regAddr,        // Register address
  input  wire logic [15:0] wrData,         // Write word
  input  wire logic        wrStb,          // Write strobe
  input  wire logic        rdStb,          // Read strobe
  output logic      [15:0] rdData,         // Read word, next cycle
  input  wire logic        alertHighEv,    // Alert high event
  input  wire logic        alertLowEv,     // Alert low event
  input  wire logic        crcFaultEv,     // Write checksum fault
  input  wire logic        setupFaultEv,   // Setup load failure
  output logic             resolutionBoost,   // Wider results
  output logic             referenceSourceSelect, // 1 = external
  output logic             powerDownSelect,   // 1 = power-down
  output logic      [3:0]  oversamplingRatio, // 0 = off
  output logic             outputLaneSelect,  // 1 = one lane
  output logic             secondLaneData,    // Lane two carries data
  output logic             softResetPulse,    // Soft reset strobe
  output logic             hardResetPulse,    // Hard reset strobe
  output logic             setupRestart       // Setup restart strobe
);
  import acrr_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [11:0] cfg1_r;
  logic [11:0] cfg2_r;
  logic [11:0] alert_r;
  logic [11:0] alert_nxt;
  logic [15:0] rdData_r;
  logic [15:0] rdData_nxt;
  acrr_cmd_if  cmd ();

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic wrCfg1  = wrStb && (regAddr == ADDR_CFG1);
  wire logic wrCfg2  = wrStb && (regAddr == ADDR_CFG2);
  wire logic rdAlert = rdStb && (regAddr == ADDR_ALERT);
  wire logic [7:0] cmdByte = wrData[7:0];
  assign cmd.softReq = wrCfg2 && (cmdByte == CODE_SOFT);
  assign cmd.hardReq = wrCfg2 && (cmdByte == CODE_HARD);
  wire logic softNow = cmd.softPulse;
  wire logic hardNow = cmd.hardPulse;

  // Events: set wins over read-clear; setup flag ignores reads
  wire logic [11:0] evSet = {2'b00, crcFaultEv, setupFaultEv,
                             2'b00, alertHighEv, alertLowEv, 4'h0};
  wire logic [11:0] readClr = rdAlert ? ALERT_MASK : 12'h000;
  wire logic [11:0] softClr = softNow ? ALERT_MASK : 12'h000;
  wire logic [11:0] hardClr = hardNow ? 12'hFFF : 12'h000;
  assign alert_nxt = ((alert_r & ~(readClr | softClr | hardClr)) | evSet)
                     & (ALERT_MASK | 12'h100);

  // Address stamped into every returned word
  always_comb begin
    rdData_nxt = 16'h0000;
    if (rdStb) begin
      unique case (regAddr)
        ADDR_CFG1:  rdData_nxt = {ADDR_CFG1, cfg1_r};
        ADDR_CFG2:  rdData_nxt = {ADDR_CFG2, cfg2_r};
        ADDR_ALERT: rdData_nxt = {ADDR_ALERT, alert_r};
        default:    rdData_nxt = {regAddr, 12'h000};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg1_r <= CFG1_RESET[11:0];
    end else if (hardNow) begin
      cfg1_r <= CFG1_RESET[11:0];
    end else if (wrCfg1) begin
      cfg1_r <= wrData[11:0] & CFG1_MASK;
    end
  end

  // Reset byte never stored: one-shot command
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg2_r <= CFG2_RESET[11:0];
    end else if (hardNow) begin
      cfg2_r <= CFG2_RESET[11:0];
    end else if (wrCfg2) begin
      cfg2_r <= wrData[11:0] & CFG2_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alert_r <= ALERT_RESET[11:0];
    end else begin
      alert_r <= alert_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 16'h0000;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Submodules and outputs
  // ----------------------------------------------------------------
  acrr_reset_seq uSeq (
    .ref_clk (ref_clk),
    .rst     (rst),
    .cmd     (cmd)
  );

  acrr_ratio_dec uDec (
    .ratioCode (cfg1_r[OSR_MSB:OSR_LSB]),
    .boostBit  (cfg1_r[BIT_RES]),
    .ratio     (oversamplingRatio),
    .boostOn   (resolutionBoost)
  );

  assign rdData = rdData_r;
  assign referenceSourceSelect = cfg1_r[BIT_REF];
  assign powerDownSelect = cfg1_r[BIT_PWR];
  assign outputLaneSelect = cfg2_r[BIT_LANE];
  assign secondLaneData = !cfg2_r[BIT_LANE];
  assign softResetPulse = softNow;
  assign hardResetPulse = hardNow;
  assign setupRestart = hardNow;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence softWrite_s;
    wrStb && (regAddr == ADDR_CFG2) && (wrData[7:0] == CODE_SOFT)
      && !cmd.hardReq;
  endsequence

  sequence hardWrite_s;
    wrStb && (regAddr == ADDR_CFG2) && (wrData[7:0] == CODE_HARD);
  endsequence

  softPulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    softWrite_s ##1 !hardNow |-> softNow ##1 !softNow)
    else $error("soft reset pulse missing");

  hardDefault_a: assert property (@(posedge ref_clk) disable iff (rst)
    hardWrite_s ##1 hardNow |=> (cfg1_r == 12'h000)
      && (cfg2_r == 12'h000))
    else $error("hard reset left registers set");

  boostOff_a: assert property (@(posedge ref_clk) disable iff (rst)
    (oversamplingRatio == RATIO_OFF) |-> !resolutionBoost)
    else $error("boost active without oversampling");

  softKeeps_a: assert property (@(posedge ref_clk) disable iff (rst)
    softNow && !wrStb |=> $stable(cfg1_r))
    else $error("soft reset changed configuration");

  softClear_a: assert property (@(posedge ref_clk) disable iff (rst)
    softNow && !alertHighEv && !alertLowEv && !crcFaultEv
      |=> (alert_r[5:4] == 2'b00) && !alert_r[BIT_CRCWF])
    else $error("soft reset left alert flags");

  otherCode_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrCfg2 && (cmdByte != CODE_SOFT) && (cmdByte != CODE_HARD)
      && !softNow && !hardNow |=> !softNow && !hardNow)
    else $error("reset action on ignored code");

  stickyRead_a: assert property (@(posedge ref_clk) disable iff (rst)
    rdAlert && !crcFaultEv && !softNow && !hardNow
      |=> !alert_r[BIT_CRCWF] && (rdData[BIT_CRCWF] == $past(
      alert_r[BIT_CRCWF])))
    else $error("checksum flag not cleared by read");

  setupHold_a: assert property (@(posedge ref_clk) disable iff (rst)
    alert_r[BIT_SETUPF] && !hardNow |=> alert_r[BIT_SETUPF])
    else $error("setup flag lost without hard reset");

  addrStamp_a: assert property (@(posedge ref_clk) disable iff (rst)
    rdStb |=> rdData[15:12] == $past(regAddr))
    else $error("returned word lacks its address");

  laneMode_a: assert property (@(posedge ref_clk) disable iff (rst)
    wrCfg2 && !hardNow |=> outputLaneSelect == $past(wrData[BIT_LANE]))
    else $error("lane select not updated");
endmodule
`default_nettype wire

// file: logic/acrr_pkg.sv
// Constants, register map and field layout of the configuration registers.
// Assumes a single ref_clk domain and a plain strobe register port.
`default_nettype none
package acrr_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CFG1 = 4'h1;
  localparam logic [3:0] ADDR_CFG2 = 4'h2;
  localparam logic [3:0] ADDR_ALERT = 4'h3;
  localparam logic [15:0] CFG1_RESET = 16'h0000;
  localparam logic [15:0] CFG2_RESET = 16'h0000;
  localparam logic [15:0] ALERT_RESET = 16'h0000;
  localparam int unsigned ADDR_LSB = 12;
  localparam int unsigned BIT_PWR = 0;
  localparam int unsigned BIT_REF = 1;
  localparam int unsigned BIT_RES = 2;
  localparam int unsigned OSR_LSB = 6;
  localparam int unsigned OSR_MSB = 8;
  localparam logic [11:0] CFG1_MASK = 12'h1FF;
  localparam int unsigned BIT_LANE = 8;
  localparam logic [11:0] CFG2_MASK = 12'h100;
  localparam int unsigned BIT_SETUPF = 8;
  localparam int unsigned BIT_CRCWF = 9;
  localparam logic [11:0] ALERT_MASK = 12'h230;
  localparam logic [7:0] CODE_SOFT = 8'h3C;
  localparam logic [7:0] CODE_HARD = 8'hFF;
  localparam logic [2:0] OSR_X2 = 3'h1;
  localparam logic [2:0] OSR_X4 = 3'h2;
  localparam logic [2:0] OSR_X8 = 3'h3;
  localparam logic [3:0] RATIO_OFF = 4'h0;
  localparam logic [3:0] RATIO_X2 = 4'h2;
  localparam logic [3:0] RATIO_X4 = 4'h4;
  localparam logic [3:0] RATIO_X8 = 4'h8;
  typedef enum logic [1:0] {
    ACRR_IDLE_type_s = 2'b00,
    ACRR_SOFT_s      = 2'b01,
    ACRR_HARD_s      = 2'b11
  } acrr_rst_type;
endpackage
`default_nettype wire

// file: logic/acrr_cmd_if.sv
// Reset command carrier between the register core and its sequencer.
// Assumes both ends run on ref_clk.
`default_nettype none
interface acrr_cmd_if;
  logic softReq;
  logic hardReq;
  logic softPulse;
  logic hardPulse;
  modport core (output softReq, output hardReq,
                input softPulse, input hardPulse);
  modport seq (input softReq, input hardReq,
               output softPulse, output hardPulse);
endinterface
`default_nettype wire

// file: logic/acrr_reset_seq.sv
// One-shot reset sequencer: turns a reset code write into a single pulse.
// Assumes requests come from logic on ref_clk.
`default_nettype none
module acrr_reset_seq
  import acrr_pkg::*;
(
  input  wire logic ref_clk, // Clock
  input  wire logic rst,     // Async reset
  acrr_cmd_if.seq   cmd      // Command carrier
);
  import acrr_pkg::*;
  acrr_rst_type state_r;
  acrr_rst_type state_nxt;

  // Hard wins over soft; each request yields one pulse
  always_comb begin
    state_nxt = ACRR_IDLE_type_s;
    unique case (state_r)
      ACRR_IDLE_type_s: begin
        if (cmd.hardReq) begin
          state_nxt = ACRR_HARD_s;
        end else if (cmd.softReq) begin
          state_nxt = ACRR_SOFT_s;
        end
      end
      // Back-to-back writes must not be dropped
      ACRR_SOFT_s, ACRR_HARD_s: begin
        if (cmd.hardReq) begin
          state_nxt = ACRR_HARD_s;
        end else if (cmd.softReq) begin
          state_nxt = ACRR_SOFT_s;
        end
      end
      default:     state_nxt = ACRR_IDLE_type_s;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ACRR_IDLE_type_s;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cmd.softPulse = (state_r == ACRR_SOFT_s);
  assign cmd.hardPulse = (state_r == ACRR_HARD_s);

  oneShot_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmd.hardPulse && !cmd.hardReq |=> !cmd.hardPulse)
    else $error("hard reset pulse repeated");
endmodule
`default_nettype wire

// file: logic/acrr_ratio_dec.sv
// Oversampling ratio and effective resolution decode.
// Assumes a stable configuration word from the register core.
`default_nettype none
module acrr_ratio_dec
  import acrr_pkg::*;
(
  input  wire logic [2:0] ratioCode, // Ratio field
  input  wire logic       boostBit,  // Resolution bit
  output logic      [3:0] ratio,     // Decoded ratio, 0 = off
  output logic            boostOn    // Wider results active
);
  import acrr_pkg::*;
  wire logic isX2 = (ratioCode == OSR_X2);
  wire logic isX4 = (ratioCode == OSR_X4);
  wire logic isX8 = (ratioCode == OSR_X8);
  assign ratio = isX2 ? RATIO_X2 : isX4 ? RATIO_X4 :
                 isX8 ? RATIO_X8 : RATIO_OFF;
  assign boostOn = boostBit && (ratio != RATIO_OFF);
endmodule
`default_nettype wire

// file: test/acrr_host_model.sv
// Host model: drives the register port with one-cycle strobes.
// Assumes the core answers a read in the cycle after the strobe.
`default_nettype none
module acrr_host_model (
  input  wire logic        ref_clk, // Clock
  input  wire logic [15:0] rdData,  // Read word
  output logic      [3:0]  regAddr, // Register address
  output logic      [15:0] wrData,  // Write word
  output logic             wrStb,   // Write strobe
  output logic             rdStb    // Read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Bus cycles
  // ----
  initial begin
    regAddr = 4'h0;
    wrData  = 16'h0000;
    wrStb   = 1'b0;
    rdStb   = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    wrData  <= {a, d};
    wrStb   <= 1'b1;
    @(posedge ref_clk);
    wrStb   <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    rdStb   <= 1'b1;
    @(posedge ref_clk);
    rdStb   <= 1'b0;
    #1 d = rdData;
  endtask
endmodule
`default_nettype wire

// file: test/adc_config_reset_registers_tb.sv
// Bench for the configuration register core.
// Assumes the host model issues all register traffic.
`default_nettype none
module adc_config_reset_registers_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import acrr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] evs = 4'h0;
  wire logic [3:0] regAddr;
  wire logic [15:0] wrData, rdData, outs;
  wire logic wrStb, rdStb, resolutionBoost, referenceSourceSelect;
  wire logic powerDownSelect, outputLaneSelect, secondLaneData;
  wire logic softResetPulse, hardResetPulse, setupRestart;
  wire logic [3:0] oversamplingRatio;
  int failCount = 0, nTests = 0, cyc = 0, sc = 0, hc = 0, rc = 0;
  logic [3:0] ratTab [8] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
  logic [7:0] codes [4] = '{8'h00, 8'h3D, 8'hFE, 8'h3B};
  assign outs = {7'h00, resolutionBoost, referenceSourceSelect,
                 powerDownSelect, oversamplingRatio, outputLaneSelect,
                 secondLaneData};
  always #2 ref_clk = ~ref_clk;
  acrr_host_model host (.ref_clk(ref_clk), .rdData(rdData),
    .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb));
  adc_config_reset_registers DUT (.ref_clk(ref_clk), .rst(rst),
    .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .alertHighEv(evs[3]), .alertLowEv(evs[2]),
    .crcFaultEv(evs[1]), .setupFaultEv(evs[0]),
    .resolutionBoost(resolutionBoost),
    .referenceSourceSelect(referenceSourceSelect),
    .powerDownSelect(powerDownSelect),
    .oversamplingRatio(oversamplingRatio),
    .outputLaneSelect(outputLaneSelect), .secondLaneData(secondLaneData),
    .softResetPulse(softResetPulse), .hardResetPulse(hardResetPulse),
    .setupRestart(setupRestart));
  // ----
  // Pulse counters and hang guard
  // ----
  always @(posedge ref_clk) begin
    sc += (softResetPulse === 1'b1);
    hc += (hardResetPulse === 1'b1);
    rc += (setupRestart === 1'b1);
    cyc++;
    if (cyc == 6000) begin
      failCount++;
      reportAndStop();
    end
  end
  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [15:0] e);
    logic [15:0] d;
    host.rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Write, then count reset pulses over the following cycles
  task automatic wrp(input logic [11:0] d, input logic [11:0] e);
    int s, h, r;
    s = sc;
    h = hc;
    r = rc;
    host.wr(ADDR_CFG2, d);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("pulses", {4'h0, e}, {4'h0, 4'(sc - s), 4'(hc - h), 4'(rc - r)});
  endtask
  task automatic ev(input logic [3:0] m);
    @(posedge ref_clk);
    evs <= m;
    @(posedge ref_clk);
    evs <= 4'h0;
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk("reset outs", 16'h0001, outs);
    rdc("cfg2", ADDR_CFG2, 16'h2000);
    rdc("alert", ADDR_ALERT, 16'h3000);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      host.wr(ADDR_CFG1, {3'h0, 3'(c), 6'h07});
      settle();
      chk("cfg1 outs", {7'h00, ratTab[c] != 4'h0, 2'h3, ratTab[c], 2'h1},
          outs);
      rdc("cfg1", ADDR_CFG1, {ADDR_CFG1, 3'h0, 3'(c), 6'h07});
    end
    host.wr(ADDR_CFG1, 12'h0C1);
    settle();
    chk("cfg1 outs", {7'h00, 3'h1, 4'h8, 2'h1}, outs);
    $display("test config one done");
    wrp(12'h100, 12'h000);
    chk("lane outs", {7'h00, 3'h1, 4'h8, 2'h2}, outs);
    rdc("cfg2", ADDR_CFG2, 16'h2100);
    foreach (codes[i]) wrp({4'h1, codes[i]}, 12'h000);
    $display("test lane and codes done");
    ev(4'hF);
    rdc("alert", ADDR_ALERT, 16'h3330);
    rdc("alert", ADDR_ALERT, 16'h3100);
    ev(4'hA);
    wrp(12'h13C, 12'h100);
    rdc("alert", ADDR_ALERT, 16'h3100);
    rdc("cfg1", ADDR_CFG1, 16'h10C1);
    rdc("cfg2", ADDR_CFG2, 16'h2100);
    $display("test soft reset done");
    wrp(12'h0FF, 12'h011);
    rdc("cfg1", ADDR_CFG1, 16'h1000);
    rdc("cfg2", ADDR_CFG2, 16'h2000);
    rdc("alert", ADDR_ALERT, 16'h3000);
    chk("hard outs", 16'h0001, outs);
    $display("test hard reset done");
    host.wr(4'h5, 12'hFFF);
    rdc("unmapped", 4'h5, 16'h5000);
    rdc("cfg1", ADDR_CFG1, 16'h1000);
    $display("test unmapped done");
    reportAndStop();
  end
endmodule
`default_nettype wire
